/* core/dsf_pkg.sv */
// package: constants, types and register map of the drive status flag block
package dsf_pkg;

  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int NUM_TERM = 5;
  localparam int FUNC_W = 4;

  // flag function codes, one bit each in the flag vector
  localparam logic [FUNC_W-1:0] FN_NONE = 4'h0;
  localparam logic [FUNC_W-1:0] FN_READY = 4'h1;
  localparam logic [FUNC_W-1:0] FN_ZSPEED = 4'h2;
  localparam logic [FUNC_W-1:0] FN_TSPEED = 4'h3;
  localparam logic [FUNC_W-1:0] FN_POS = 4'h4;
  localparam logic [FUNC_W-1:0] FN_TQLIM = 4'h5;
  localparam logic [FUNC_W-1:0] FN_ALARM = 4'h6;
  localparam logic [FUNC_W-1:0] FN_BRAKE = 4'h7;
  localparam logic [FUNC_W-1:0] FN_OVLD = 4'h8;
  localparam logic [FUNC_W-1:0] FN_WARN = 4'h9;
  localparam logic [FUNC_W-1:0] FN_SCMP = 4'hA;
  localparam int NUM_FLAGS = 11;

  // control modes
  typedef enum logic [2:0] {
    MODE_PT, MODE_S, MODE_T, MODE_SZ, MODE_TZ, MODE_PT_S, MODE_PT_T, MODE_S_T
  } dsf_mode_t;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ZERO_SPEED_FLAG_WIN = 8'h04;
  localparam logic [7:0] OFS_TGT_SPD = 8'h08;
  localparam logic [7:0] OFS_INPOS = 8'h0C;
  localparam logic [7:0] OFS_SPDERR = 8'h10;
  localparam logic [7:0] OFS_OVLD = 8'h14;
  localparam logic [7:0] OFS_ASSIGN = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_TERM = 8'h28;

  // ctrl fields: [2:0] mode, [3] use custom assignment, [4] brake release
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CUSTOM_BIT = 3;
  localparam int CTRL_BRAKE_BIT = 4;
  // assignment register: per terminal 4-bit function, active-low bit at 20+i
  localparam int ASSIGN_POL_LSB = 20;

  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [VAL_W-1:0] ZERO_SPEED_FLAG_WIN_RST = 16'h000A;
  localparam logic [VAL_W-1:0] TGT_SPD_RST = 16'h0BB8;
  localparam logic [VAL_W-1:0] INPOS_RST = 16'h0064;
  localparam logic [VAL_W-1:0] SPDERR_RST = 16'h000A;
  localparam logic [VAL_W-1:0] OVLD_RST = 16'h0078;
  localparam logic [DATA_W-1:0] ASSIGN_RST = 32'h0000_0000;

  // measured drive quantities and fault state from the control path
  typedef struct packed {
    logic [VAL_W-1:0] speed_abs;
    logic [VAL_W-1:0] speed_err_abs;
    logic [VAL_W-1:0] pos_err_abs;
    logic [VAL_W-1:0] load_level;
    logic torque_at_limit;
    logic drive_able;
    logic fault_other;
    logic rev_limit;
    logic fwd_limit;
    logic emg_stop;
    logic comm_err;
    logic under_volt;
  } dsf_meas_t;

endpackage

/* core/dsf_assign_mem.sv */
// small memory holding the per-terminal output assignments
`timescale 1ns/100ps
module dsf_assign_mem #(
  parameter int DEPTH = 5,
  parameter int WIDTH = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  if (DEPTH < 2)
  begin : g_bad_depth
    $error("depth must be at least 2");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      rd_data <= '0;
    end
    else
    begin
      if (wr_en) mem_q[wr_addr] <= wr_data;
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

/* core/dsf_status_flags.sv */
// drive status flag generator with programmable output terminals over APB
//
// What this block does
// - ready is high only while the drive can run and no fault, alarm or warning is present.
// - zero speed is high whenever measured speed is at or below the zero-speed window.
// - target speed is high once speed reaches the target, in every mode but pulse-train.
// - in pulse-train position modes, position reached is high when error is within threshold.
// - torque limit follows the torque-at-limit detection and has no default terminal.
// - alarm is high on any fault except the five warning-class faults.
// - limit, emergency stop, comms and undervoltage faults raise warning, never alarm.
// - warning is high while any of the five warning-class faults is present, in every mode.
// - overload is high once load reaches the configured overload level.
// - in speed modes, speed compare is high when speed error is within threshold.
// - the brake output is available in every mode and has no default terminal.
// - the function shown on each output terminal is chosen by configuration.
// - a mode-dependent default assignment applies; unassigned functions drive no terminal.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module dsf_status_flags #(
  parameter int NTERM = dsf_pkg::NUM_TERM
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsf_pkg::dsf_meas_t meas,
  output logic [NTERM-1:0] term_out,
  output logic brake_control_out,
  output logic irq
);
  import dsf_pkg::*;

  // the assignment register packs five 4-bit codes and five polarity bits
  if (NTERM < 2 || NTERM > 5)
  begin : g_bad_nterm
    $error("terminal count must be 2 to 5");
  end

  localparam int TA_W = $clog2(NTERM);

  // measured inputs come from another domain: two-flop synchroniser
  // a multi-bit value may be torn for one cycle; the compare settles on the next one
  dsf_meas_t meas_s1_q;
  dsf_meas_t meas_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meas_s1_q <= '0;
      meas_q <= '0;
    end
    else
    begin
      meas_s1_q <= meas;
      meas_q <= meas_s1_q;
    end
  end

  // register file
  logic [31:0] ctrl_q;
  logic [VAL_W-1:0] zero_speed_flag_win_q;
  logic [VAL_W-1:0] tgt_spd_q;
  logic [VAL_W-1:0] inpos_q;
  logic [VAL_W-1:0] spderr_q;
  logic [VAL_W-1:0] ovld_q;
  logic [31:0] assign_q;
  logic [NUM_FLAGS-1:0] irq_stat_q;
  logic [NUM_FLAGS-1:0] irq_mask_q;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire setup = psel && !penable;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_zero_speed_flag = paddr == OFS_ZERO_SPEED_FLAG_WIN;
  wire hit_tgt = paddr == OFS_TGT_SPD;
  wire hit_inpos = paddr == OFS_INPOS;
  wire hit_spderr = paddr == OFS_SPDERR;
  wire hit_ovld = paddr == OFS_OVLD;
  wire hit_assign = paddr == OFS_ASSIGN;
  wire hit_flags = paddr == OFS_FLAGS;
  wire hit_stat = paddr == OFS_IRQ_STAT;
  wire hit_mask = paddr == OFS_IRQ_MASK;
  wire hit_term = paddr == OFS_TERM;
  wire mapped = hit_ctrl | hit_zero_speed_flag | hit_tgt | hit_inpos | hit_spderr | hit_ovld
    | hit_assign | hit_flags | hit_stat | hit_mask | hit_term;

  // one short process per register; writes land at the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) ctrl_q <= CTRL_RST;
    else if (wr && hit_ctrl) ctrl_q <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) zero_speed_flag_win_q <= ZERO_SPEED_FLAG_WIN_RST;
    else if (wr && hit_zero_speed_flag) zero_speed_flag_win_q <= pwdata[VAL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) tgt_spd_q <= TGT_SPD_RST;
    else if (wr && hit_tgt) tgt_spd_q <= pwdata[VAL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) inpos_q <= INPOS_RST;
    else if (wr && hit_inpos) inpos_q <= pwdata[VAL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) spderr_q <= SPDERR_RST;
    else if (wr && hit_spderr) spderr_q <= pwdata[VAL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) ovld_q <= OVLD_RST;
    else if (wr && hit_ovld) ovld_q <= pwdata[VAL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) assign_q <= ASSIGN_RST;
    else if (wr && hit_assign) assign_q <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) irq_mask_q <= '0;
    else if (wr && hit_mask) irq_mask_q <= pwdata[NUM_FLAGS-1:0];
  end

  // mode decode
  dsf_mode_t mode;
  assign mode = dsf_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
  wire custom_en = ctrl_q[CTRL_CUSTOM_BIT];
  wire brake_req = ctrl_q[CTRL_BRAKE_BIT];

  function automatic logic is_pos_mode(input dsf_mode_t m);
    return m == MODE_PT || m == MODE_PT_S || m == MODE_PT_T;
  endfunction

  function automatic logic is_speed_mode(input dsf_mode_t m);
    return m == MODE_S || m == MODE_SZ;
  endfunction

  // flag logic, all combinational here and registered below
  wire warn_any = meas_q.rev_limit | meas_q.fwd_limit | meas_q.emg_stop
    | meas_q.comm_err | meas_q.under_volt;
  wire alarm_c = meas_q.fault_other;
  wire ready_c = meas_q.drive_able && !alarm_c && !warn_any;
  wire zero_speed_flag_c = meas_q.speed_abs <= zero_speed_flag_win_q;
  wire target_speed_flag_c = !(mode == MODE_PT) && meas_q.speed_abs >= tgt_spd_q;
  wire pos_c = is_pos_mode(mode) && meas_q.pos_err_abs <= inpos_q;
  wire tql_c = meas_q.torque_at_limit;
  wire ovld_c = meas_q.load_level >= ovld_q;
  wire scmp_c = is_speed_mode(mode) && meas_q.speed_err_abs <= spderr_q;
  // brake engaged unless released while the drive is ready
  wire brake_c = !(brake_req && ready_c);

  logic [NUM_FLAGS-1:0] flags_d;
  always_comb
  begin
    flags_d = '0;
    flags_d[FN_READY] = ready_c;
    flags_d[FN_ZSPEED] = zero_speed_flag_c;
    flags_d[FN_TSPEED] = target_speed_flag_c;
    flags_d[FN_POS] = pos_c;
    flags_d[FN_TQLIM] = tql_c;
    flags_d[FN_ALARM] = alarm_c;
    flags_d[FN_BRAKE] = brake_c;
    flags_d[FN_OVLD] = ovld_c;
    flags_d[FN_WARN] = warn_any;
    flags_d[FN_SCMP] = scmp_c;
  end

  // one registered copy feeds terminals and brake; status edges compare it with the unregistered flags_d
  logic [NUM_FLAGS-1:0] flags_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) flags_q <= '0;
    else flags_q <= flags_d;
  end

  // sticky status on rising flag edges; a set in the clear cycle wins
  wire [NUM_FLAGS-1:0] rise = flags_d & ~flags_q;
  wire [NUM_FLAGS-1:0] clr = (wr && hit_stat) ? pwdata[NUM_FLAGS-1:0] : '0;
  wire [NUM_FLAGS-1:0] stat_d = (irq_stat_q & ~clr) | rise;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) irq_stat_q <= '0;
    else irq_stat_q <= stat_d;
  end

  // default terminal assignment per mode; unused functions get no pin
  function automatic logic [FUNC_W-1:0] default_func(input dsf_mode_t m, input int t);
    case (t)
      0: return FN_READY;
      1: return FN_ZSPEED;
      2: return is_pos_mode(m) ? FN_POS : (m == MODE_S ? FN_TSPEED : FN_NONE);
      3: return FN_ALARM;
      default: return FN_NONE;
    endcase
  endfunction

  // custom assignments stored in the small memory, scanned one terminal a cycle
  // a single read port keeps the memory small; each terminal refreshes every NTERM cycles
  logic [TA_W-1:0] scan_q;
  logic [4:0] mem_rd;
  wire mem_we = wr && hit_assign;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) scan_q <= '0;
    else scan_q <= (scan_q == TA_W'(NTERM - 1)) ? '0 : scan_q + 1'b1;
  end

  logic [TA_W-1:0] scan_d1_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) scan_d1_q <= '0;
    else scan_d1_q <= scan_q;
  end

  // one write updates all terminals' entries over successive cycles
  // reset starts one pass too, so the memory mirrors the reset assignment value
  logic [TA_W-1:0] wr_idx_q;
  logic wr_busy_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_idx_q <= '0;
      wr_busy_q <= 1'b1;
    end
    else if (mem_we)
    begin
      wr_idx_q <= '0;
      wr_busy_q <= 1'b1;
    end
    else if (wr_busy_q)
    begin
      wr_busy_q <= wr_idx_q != TA_W'(NTERM - 1);
      wr_idx_q <= (wr_idx_q == TA_W'(NTERM - 1)) ? wr_idx_q : wr_idx_q + 1'b1;
    end
  end

  wire [4:0] mem_wdata = {assign_q[ASSIGN_POL_LSB + wr_idx_q],
    assign_q[wr_idx_q*FUNC_W +: FUNC_W]};

  dsf_assign_mem #(
    .DEPTH(NTERM),
    .WIDTH(5)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_busy_q && !mem_we),
    .wr_addr(wr_idx_q),
    .wr_data(mem_wdata),
    .rd_addr(scan_q),
    .rd_data(mem_rd)
  );

  logic [NTERM-1:0] term_q;
  genvar g;
  generate
    for (g = 0; g < NTERM; g++)
    begin : g_term
      wire [FUNC_W-1:0] dfn = default_func(mode, g);
      wire [FUNC_W-1:0] cfn = mem_rd[FUNC_W-1:0];
      wire cpol = mem_rd[FUNC_W];
      wire cval = (cfn != FN_NONE && cfn < FUNC_W'(NUM_FLAGS)) ? flags_q[cfn] ^ cpol : 1'b0;
      wire dval = (dfn != FN_NONE) ? flags_q[dfn] : 1'b0;
      logic bit_q;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn) bit_q <= 1'b0;
        else if (!custom_en) bit_q <= dval;
        else if (scan_d1_q == TA_W'(g)) bit_q <= cval;
      end
      assign term_q[g] = bit_q;
    end
  endgenerate

  assign term_out = term_q;
  assign brake_control_out = flags_q[FN_BRAKE];

  // APB answer: zero wait states, unmapped addresses give pslverr
  logic [31:0] rdata_d;
  always_comb
  begin
    rdata_d = '0;
    if (hit_ctrl) rdata_d = ctrl_q;
    if (hit_zero_speed_flag) rdata_d = {16'h0000, zero_speed_flag_win_q};
    if (hit_tgt) rdata_d = {16'h0000, tgt_spd_q};
    if (hit_inpos) rdata_d = {16'h0000, inpos_q};
    if (hit_spderr) rdata_d = {16'h0000, spderr_q};
    if (hit_ovld) rdata_d = {16'h0000, ovld_q};
    if (hit_assign) rdata_d = assign_q;
    if (hit_flags) rdata_d = {21'h000000, flags_q};
    if (hit_stat) rdata_d = {21'h000000, irq_stat_q};
    if (hit_mask) rdata_d = {21'h000000, irq_mask_q};
    if (hit_term) rdata_d = {{(32-NTERM){1'b0}}, term_q};
  end

  // registered answer: setup cycle prepares, access cycle completes
  // read-only targets ignore writes quietly; only unmapped addresses raise pslverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // read data is launched at setup so it stands for the whole access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) prdata <= '0;
    else if (setup && !pwrite) prdata <= rdata_d;
  end

  // irq follows the next status value so it never lags the sticky bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(stat_d & irq_mask_q);
  end
endmodule

/* dv/dsf_status_flags_props.sv */
// checker: bus handshake and brake behaviour at the block's ports
`timescale 1ns/100ps
module dsf_status_flags_props #(
  parameter int NTERM = dsf_pkg::NUM_TERM
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dsf_pkg::dsf_meas_t meas,
  input wire logic [NTERM-1:0] term_out,
  input wire logic brake_control_out,
  input wire logic irq
);
  import dsf_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // zero wait states: the first access cycle answers
  property p_answer;
    s_setup ##1 s_access |-> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer in access cycle");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer held too long");
  property p_only;
    !(psel && penable) |-> !pready;
  endproperty
  a_only: assert property (p_only) else $error("answer outside access");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without answer");
  property p_unmapped;
    s_access and paddr > OFS_TERM |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  // six cycles cover the two-flop input sync and the flag register
  property p_fault_brake;
    meas.fault_other [*6] |-> brake_control_out;
  endproperty
  a_fault_brake: assert property (p_fault_brake) else $error("brake off in fault");
  property p_warn_brake;
    (|meas[4:0]) [*6] |-> brake_control_out;
  endproperty
  a_warn_brake: assert property (p_warn_brake) else $error("brake off in warning");
  property p_unable_brake;
    !meas.drive_able [*6] |-> brake_control_out;
  endproperty
  a_unable_brake: assert property (p_unable_brake) else $error("brake off when unable");
endmodule
bind dsf_status_flags dsf_status_flags_props #(.NTERM(NTERM)) dsf_status_flags_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas(meas), .term_out(term_out), .brake_control_out(brake_control_out), .irq(irq));

/* dv/dsf_ctrl_model.sv */
// controller model: samples the status terminals once per clock
`timescale 1ns/100ps
module dsf_ctrl_model #(
  parameter int NTERM = 5
) (
  input wire logic pclk,
  input wire logic [NTERM-1:0] term_in,
  output logic [NTERM-1:0] term_seen
);
  // a real controller only sees settled levels, so it samples on the edge
  always_ff @(posedge pclk)
    term_seen <= term_in;
endmodule

/* dv/dsf_status_flags_test.sv */
// self-checking bench for the drive status flag block
`timescale 1ns/100ps
module dsf_status_flags_test;
  import dsf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_TERM-1:0] term_out;
  logic [NUM_TERM-1:0] term_seen;
  logic brake_control_out;
  logic irq;
  logic [31:0] rd;
  logic err;
  dsf_meas_t meas = '0;
  int err_count = 0;
  int n_tests = 0;
  always #10 pclk = ~pclk;
  dsf_status_flags dsf_status_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .term_out(term_out),
    .brake_control_out(brake_control_out), .irq(irq));
  dsf_ctrl_model dsf_ctrl_model_inst (.pclk(pclk), .term_in(term_out), .term_seen(term_seen));
  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("unexpected at %0t: no bus answer", $time);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // flags take 3 cycles, custom terminals NTERM+2 more, plus the model stage
  task automatic wt;
    repeat (NUM_TERM + 6) @(posedge pclk);
  endtask
  task automatic flag(input int b, input logic v);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk(32'(rd[b]), 32'(v));
  endtask
  task automatic sp(input logic [15:0] s, input logic [15:0] e, input logic [15:0] l,
    input int b, input logic v);
    meas.speed_abs <= s;
    meas.speed_err_abs <= e;
    meas.load_level <= l;
    wt();
    flag(b, v);
  endtask
  task automatic s_regs;
    logic [7:0] a [7];
    logic [31:0] e [7];
    a = '{OFS_CTRL, OFS_ZERO_SPEED_FLAG_WIN, OFS_TGT_SPD, OFS_INPOS, OFS_SPDERR, OFS_OVLD, OFS_ASSIGN};
    e = '{CTRL_RST, 32'(ZERO_SPEED_FLAG_WIN_RST), 32'(TGT_SPD_RST), 32'(INPOS_RST), 32'(SPDERR_RST),
      32'(OVLD_RST), ASSIGN_RST};
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, e[i]);
    end
    apb(1'b1, 8'h2C, 32'hFFFF_FFFF);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h2C, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic s_default;
    meas.drive_able <= 1'b1;
    meas.pos_err_abs <= INPOS_RST;
    wt();
    chk(32'(term_seen), 32'h7);
    chk(32'(brake_control_out), 32'h1);
    meas.pos_err_abs <= INPOS_RST + 16'h1;
    wt();
    chk(32'(term_seen), 32'h3);
    meas.fault_other <= 1'b1;
    wt();
    chk(32'(term_seen), 32'hA);
    meas.fault_other <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      meas[4:0] <= 5'(1 << i);
      wt();
      chk(32'(term_seen), 32'h2);
      flag(9, 1'b1);
    end
    meas[4:0] <= 5'h0;
  endtask
  task automatic s_speed;
    apb(1'b1, OFS_CTRL, 32'(MODE_S));
    sp(ZERO_SPEED_FLAG_WIN_RST, 16'h0, 16'h0, 2, 1'b1);
    sp(ZERO_SPEED_FLAG_WIN_RST + 16'h1, 16'h0, 16'h0, 2, 1'b0);
    sp(TGT_SPD_RST, 16'h0, 16'h0, 3, 1'b1);
    chk(32'(term_seen), 32'h5);
    sp(TGT_SPD_RST - 16'h1, 16'h0, 16'h0, 3, 1'b0);
    sp(16'h0, SPDERR_RST, 16'h0, 10, 1'b1);
    sp(16'h0, SPDERR_RST + 16'h1, 16'h0, 10, 1'b0);
    sp(16'h0, 16'h0, OVLD_RST, 8, 1'b1);
    sp(16'h0, 16'h0, OVLD_RST - 16'h1, 8, 1'b0);
    apb(1'b1, OFS_CTRL, 32'(MODE_SZ));
    sp(16'h0, SPDERR_RST, 16'h0, 10, 1'b1);
    chk(32'(term_seen), 32'h3);
    meas.pos_err_abs <= INPOS_RST;
    apb(1'b1, OFS_CTRL, 32'(MODE_T));
    sp(16'h0, 16'h0, 16'h0, 10, 1'b0);
    flag(4, 1'b0);
    apb(1'b1, OFS_CTRL, 32'(MODE_PT_T));
    wt();
    chk(32'(term_seen), 32'h7);
    apb(1'b1, OFS_CTRL, 32'(MODE_PT));
    sp(TGT_SPD_RST, 16'h0, 16'h0, 3, 1'b0);
  endtask
  task automatic s_custom;
    apb(1'b1, OFS_ASSIGN, (32'h1 << ASSIGN_POL_LSB) | 32'(FN_TQLIM));
    apb(1'b1, OFS_CTRL, (32'h1 << CTRL_CUSTOM_BIT) | (32'h1 << CTRL_BRAKE_BIT));
    wt();
    chk(32'(term_seen), 32'h1);
    chk(32'(brake_control_out), 32'h0);
    apb(1'b0, OFS_TERM, 32'h0);
    chk(rd, 32'h1);
    meas.torque_at_limit <= 1'b1;
    wt();
    chk(32'(term_seen), 32'h0);
    flag(5, 1'b1);
    meas.torque_at_limit <= 1'b0;
  endtask
  task automatic s_irq;
    apb(1'b1, OFS_IRQ_STAT, 32'hFFFF_FFFF);
    apb(1'b1, OFS_IRQ_MASK, 32'h1 << FN_ALARM);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h1 << FN_ALARM);
    meas.fault_other <= 1'b1;
    wt();
    chk(32'(irq), 32'h1);
    chk(32'(brake_control_out), 32'h1);
    meas.fault_other <= 1'b0;
    wt();
    chk(32'(irq), 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(32'(rd[FN_ALARM]), 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1 << FN_ALARM);
    wt();
    chk(32'(irq), 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    meas.fault_other <= 1'b1;
    wt();
    chk(32'(irq), 32'h0);
  endtask
  task automatic s_reset;
    apb(1'b1, OFS_ZERO_SPEED_FLAG_WIN, 32'h0000_0020);
    apb(1'b0, OFS_ZERO_SPEED_FLAG_WIN, 32'h0);
    chk(rd, 32'h0000_0020);
    sp(16'h0020, 16'h0, 16'h0, 2, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'({term_out, brake_control_out, irq, pready}), 32'h0);
    chk(prdata, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_ZERO_SPEED_FLAG_WIN, 32'h0);
    chk(rd, 32'(ZERO_SPEED_FLAG_WIN_RST));
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_default();
    s_speed();
    s_custom();
    s_irq();
    s_reset();
    end_sim();
  end
endmodule
